// ### rtl/sfr_map_decoder.v
// Register bank and address decoder for the short and extended register areas
`timescale 1ns/10ps
`default_nettype none
`include "sfr_map_defs.vh"

module sfr_map_decoder #(
    parameter NRW = `NUM_RW_REGS,
    parameter NRO = `NUM_RO_INPUTS
) (
    input wire CLOCK,
    input wire RST_B,
    input wire PWR_ON_RST_B,
    input wire [4:0] RST_CAUSE,
    input wire OPT_WDT_KEY_SEL,
    input wire ACC_VALID,
    input wire ACC_WRITE,
    input wire [19:0] ACC_ADDR,
    input wire [1:0] ACC_OP,
    input wire [2:0] ACC_BITPOS,
    input wire [7:0] ACC_WDATA,
    input wire [8*NRO-1:0] STATUS_IN,
    output reg [7:0] RDATA,
    output reg BIT_RESULT,
    output reg DONE,
    output reg REFUSED,
    output reg LONG_FORM,
    output reg [1:0] EXTRA_BYTES,
    output reg [7:0] RESET_CAUSE,
    output reg [8*NRW-1:0] CFG_OUT
);

    // Address to bank index; read/write registers first, then read-only ones
    function [5:0] reg_index;
        input [19:0] a;
        begin
            case (a)
                `ADC_MODE_2_ADDR: reg_index = 6'd0;
                `PULLUP_OPT_PORT0_ADDR: reg_index = 6'd1;
                `PULLUP_OPT_PORT1_ADDR: reg_index = 6'd2;
                `PULLUP_OPT_PORT4_ADDR: reg_index = 6'd3;
                `PULLUP_OPT_PORT12_ADDR: reg_index = 6'd4;
                `OPEN_DRAIN_SEL_PORT0_ADDR: reg_index = 6'd5;
                `OPEN_DRAIN_SEL_PORT1_ADDR: reg_index = 6'd6;
                `ANALOG_DIGITAL_SEL_PORT0_ADDR: reg_index = 6'd7;
                `ANALOG_DIGITAL_SEL_PORT1_ADDR: reg_index = 6'd8;
                `INPUT_FILTER_EN_0_ADDR: reg_index = 6'd9;
                `INPUT_FILTER_EN_1_ADDR: reg_index = 6'd10;
                `TIMER_IO_CTRL_ADDR: reg_index = 6'd11;
                `INPUT_SWITCH_CTRL_ADDR: reg_index = 6'd12;
                `PULLDOWN_OPT_PORT0_ADDR: reg_index = 6'd13;
                `PULLDOWN_OPT_PORT1_ADDR: reg_index = 6'd14;
                `PERIPHERAL_PIN_REDIRECT_ADDR: reg_index = 6'd15;
                `HS_OSC_DIVIDER_ADDR: reg_index = 6'd16;
                `PERIPHERAL_ENABLE_0_ADDR: reg_index = 6'd17;
                `SPEED_MODE_CTRL_ADDR: reg_index = 6'd18;
                `SERIAL_FLAG_CLEAR_CH0_ADDR: reg_index = 6'd19;
                `SERIAL_FLAG_CLEAR_CH1_ADDR: reg_index = 6'd20;
                `SERIAL_MODE_CH0_LO_ADDR: reg_index = 6'd21;
                `SERIAL_MODE_CH0_HI_ADDR: reg_index = 6'd22;
                `SERIAL_MODE_CH1_LO_ADDR: reg_index = 6'd23;
                `SERIAL_MODE_CH1_HI_ADDR: reg_index = 6'd24;
                `SERIAL_COMM_CFG_CH0_LO_ADDR: reg_index = 6'd25;
                `SERIAL_COMM_CFG_CH0_HI_ADDR: reg_index = 6'd26;
                `SERIAL_COMM_CFG_CH1_LO_ADDR: reg_index = 6'd27;
                `SERIAL_COMM_CFG_CH1_HI_ADDR: reg_index = 6'd28;
                `SERIAL_CHAN_START_ADDR: reg_index = 6'd29;
                `SERIAL_CHAN_STOP_ADDR: reg_index = 6'd30;
                `SERIAL_CLOCK_SEL_ADDR: reg_index = 6'd31;
                `SERIAL_OUTPUT_VALUE_ADDR: reg_index = 6'd32;
                `SERIAL_CLOCK_OUTPUT_ADDR: reg_index = 6'd33;
                `SERIAL_OUTPUT_ENABLE_ADDR: reg_index = 6'd34;
                `SERIAL_OUTPUT_LEVEL_ADDR: reg_index = 6'd35;
                `CLOCK_OUT_SELECT_ADDR: reg_index = 6'd36;
                `WATCHDOG_ENABLE_KEY_ADDR: reg_index = 6'd37;
                `IRQ_REQUEST_FLAGS_0_LO_ADDR: reg_index = 6'd38;
                `DECIMAL_ADJUST_RESULT_ADDR: reg_index = 6'd39;
                `SERIAL_STATUS_CH0_ADDR: reg_index = 6'd40;
                `SERIAL_STATUS_CH1_ADDR: reg_index = 6'd41;
                `SERIAL_CHAN_ENABLED_ADDR: reg_index = 6'd42;
                `TIMER_COUNT_CH0_LO_ADDR: reg_index = 6'd43;
                `TIMER_COUNT_CH0_HI_ADDR: reg_index = 6'd44;
                `TIMER_COUNT_CH1_LO_ADDR: reg_index = 6'd45;
                `TIMER_COUNT_CH1_HI_ADDR: reg_index = 6'd46;
                `RESET_CAUSE_FLAGS_ADDR: reg_index = `IDX_RESET_CAUSE;
                default: reg_index = `IDX_NONE;
            endcase
        end
    endfunction

    // After-reset value of each read/write register
    function [7:0] rw_reset;
        input integer i;
        begin
            case (i)
                3: rw_reset = `PULLUP_OPT_PORT4_RST;
                7: rw_reset = `RST_ONES;
                8: rw_reset = `RST_ONES;
                16: rw_reset = `HS_OSC_DIVIDER_RST;
                21: rw_reset = `SERIAL_MODE_LO_RST;
                23: rw_reset = `SERIAL_MODE_LO_RST;
                25: rw_reset = `SERIAL_COMM_CFG_LO_RST;
                27: rw_reset = `SERIAL_COMM_CFG_LO_RST;
                32: rw_reset = `SERIAL_OUT_RST;
                33: rw_reset = `SERIAL_OUT_RST;
                37: rw_reset = `WATCHDOG_KEY_RST_A;
                default: rw_reset = `RST_ZERO;
            endcase
        end
    endfunction

    // Registers that accept single-bit operations
    function bit_capable;
        input [5:0] i;
        begin
            case (i)
                6'd0, 6'd1, 6'd2, 6'd3, 6'd5, 6'd36, 6'd38: bit_capable = 1'b1;
                default: bit_capable = 1'b0;
            endcase
        end
    endfunction

    // Area decode of the incoming address
    wire in_ext = (ACC_ADDR >= `EXT_AREA_FIRST) && (ACC_ADDR <= `EXT_AREA_LAST);
    wire in_short = (ACC_ADDR >= `SHORT_AREA_FIRST) && (ACC_ADDR <= `SHORT_AREA_LAST);
    wire [5:0] raw_idx = reg_index(ACC_ADDR);
    // Only addresses inside one of the two areas decode to a register
    wire [5:0] idx = (in_ext || in_short) ? raw_idx : `IDX_NONE;
    wire is_rw = (idx < NRW);
    wire is_ro = (idx >= NRW) && (idx != `IDX_NONE);
    wire is_bitop = (ACC_OP != `OP_BYTE);
    wire bit_ok = bit_capable(idx);

    reg load_pending_r;
    reg [7:0] cur_val;
    reg [7:0] rdata_nxt;
    reg bit_nxt;
    reg refused_nxt;
    reg do_write;
    reg [7:0] wr_val;
    reg [7:0] cause_nxt;
    integer i;

    // Current contents of the addressed register; unassigned reads zero
    always @* begin
        cur_val = 8'h00;
        if (is_rw) begin
            cur_val = CFG_OUT[idx*8 +: 8];
        end else if (idx == `IDX_RESET_CAUSE) begin
            cur_val = RESET_CAUSE;
        end else if (is_ro) begin
            cur_val = STATUS_IN[(idx-NRW)*8 +: 8];
        end
    end

    // Access decision and the value to be stored
    always @* begin
        rdata_nxt = 8'h00;
        bit_nxt = 1'b0;
        refused_nxt = 1'b0;
        do_write = 1'b0;
        wr_val = cur_val;
        if (ACC_VALID) begin
            if (idx == `IDX_NONE) begin
                refused_nxt = 1'b1;
            end else if (is_bitop && !bit_ok) begin
                refused_nxt = 1'b1;
            end else if (ACC_OP == `OP_BIT_TEST) begin
                bit_nxt = cur_val[ACC_BITPOS];
                rdata_nxt = cur_val;
            end else if (!ACC_WRITE && ACC_OP == `OP_BYTE) begin
                rdata_nxt = cur_val;
            end else if (!is_rw) begin
                refused_nxt = 1'b1;
            end else begin
                do_write = 1'b1;
                case (ACC_OP)
                    `OP_BYTE: wr_val = ACC_WDATA;
                    `OP_BIT_SET: wr_val = cur_val | (8'h01 << ACC_BITPOS);
                    `OP_BIT_CLEAR: wr_val = cur_val & ~(8'h01 << ACC_BITPOS);
                    default: wr_val = cur_val;
                endcase
                rdata_nxt = wr_val;
            end
        end
    end

    // Cause flags updated from the source of the reset just ended
    always @* begin
        cause_nxt = RESET_CAUSE;
        if (RST_CAUSE[`CAUSE_PIN_BIT] || RST_CAUSE[`CAUSE_RETENTION_BIT]) begin
            cause_nxt = 8'h00;
        end else begin
            if (RST_CAUSE[`CAUSE_ILLEGAL_BIT]) begin
                cause_nxt[`ILLEGAL_INSN_FLAG_BIT] = 1'b1;
            end
            if (RST_CAUSE[`CAUSE_WATCHDOG_BIT]) begin
                cause_nxt[`WATCHDOG_RESET_FLAG_BIT] = 1'b1;
            end
            if (RST_CAUSE[`CAUSE_SUPPLY_BIT]) begin
                cause_nxt[`SUPPLY_MONITOR_RESET_FLAG_BIT] = 1'b1;
            end
        end
    end

    // Cause flags survive system resets other than pin and retention resets; power-on clears them at once
    always @(posedge CLOCK or negedge PWR_ON_RST_B) begin
        if (!PWR_ON_RST_B) begin
            RESET_CAUSE <= 8'h00;
        end else if (load_pending_r) begin
            RESET_CAUSE <= cause_nxt;
        end
    end

    // Read/write register bank
    always @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            for (i = 0; i < NRW; i = i + 1) begin
                CFG_OUT[i*8 +: 8] <= rw_reset(i);
            end
        end else if (load_pending_r) begin
            CFG_OUT[37*8 +: 8] <= OPT_WDT_KEY_SEL ? `WATCHDOG_KEY_RST_B : `WATCHDOG_KEY_RST_A;
        end else if (do_write) begin
            CFG_OUT[idx*8 +: 8] <= wr_val;
        end
    end

    // Answer path and option capture
    always @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            load_pending_r <= 1'b1;
            RDATA <= 8'h00;
            BIT_RESULT <= 1'b0;
            DONE <= 1'b0;
            REFUSED <= 1'b0;
            LONG_FORM <= 1'b0;
            EXTRA_BYTES <= 2'h0;
        end else begin
            load_pending_r <= 1'b0;
            DONE <= ACC_VALID && !load_pending_r;
            RDATA <= load_pending_r ? 8'h00 : rdata_nxt;
            BIT_RESULT <= load_pending_r ? 1'b0 : bit_nxt;
            REFUSED <= load_pending_r ? ACC_VALID : refused_nxt;
            if (ACC_VALID) begin
                LONG_FORM <= in_ext;
                EXTRA_BYTES <= in_ext ? `EXT_EXTRA_BYTES : 2'h0;
            end
        end
    end

endmodule
`default_nettype wire

// ### rtl/sfr_map_defs.vh
// Address map, reset values and field positions of the register bank
`ifndef SFR_MAP_DEFS_VH
`define SFR_MAP_DEFS_VH

`define EXT_AREA_FIRST 20'hf0000
`define EXT_AREA_LAST 20'hf07ff
`define SHORT_AREA_FIRST 20'hfff00
`define SHORT_AREA_LAST 20'hfffff
`define EXT_EXTRA_BYTES 2'h1

`define ADC_MODE_2_ADDR 20'hf0010
`define PULLUP_OPT_PORT0_ADDR 20'hf0030
`define PULLUP_OPT_PORT1_ADDR 20'hf0031
`define PULLUP_OPT_PORT4_ADDR 20'hf0034
`define PULLUP_OPT_PORT12_ADDR 20'hf003c
`define OPEN_DRAIN_SEL_PORT0_ADDR 20'hf0050
`define OPEN_DRAIN_SEL_PORT1_ADDR 20'hf0051
`define ANALOG_DIGITAL_SEL_PORT0_ADDR 20'hf0060
`define ANALOG_DIGITAL_SEL_PORT1_ADDR 20'hf0061
`define INPUT_FILTER_EN_0_ADDR 20'hf0070
`define INPUT_FILTER_EN_1_ADDR 20'hf0071
`define TIMER_IO_CTRL_ADDR 20'hf0072
`define INPUT_SWITCH_CTRL_ADDR 20'hf0073
`define PULLDOWN_OPT_PORT0_ADDR 20'hf0074
`define PULLDOWN_OPT_PORT1_ADDR 20'hf0075
`define PERIPHERAL_PIN_REDIRECT_ADDR 20'hf0077
`define HS_OSC_DIVIDER_ADDR 20'hf00a8
`define PERIPHERAL_ENABLE_0_ADDR 20'hf00f0
`define SPEED_MODE_CTRL_ADDR 20'hf00f3
`define DECIMAL_ADJUST_RESULT_ADDR 20'hf00fe
`define SERIAL_STATUS_CH0_ADDR 20'hf0100
`define SERIAL_STATUS_CH1_ADDR 20'hf0102
`define SERIAL_FLAG_CLEAR_CH0_ADDR 20'hf0108
`define SERIAL_FLAG_CLEAR_CH1_ADDR 20'hf010a
`define SERIAL_MODE_CH0_LO_ADDR 20'hf0110
`define SERIAL_MODE_CH0_HI_ADDR 20'hf0111
`define SERIAL_MODE_CH1_LO_ADDR 20'hf0112
`define SERIAL_MODE_CH1_HI_ADDR 20'hf0113
`define SERIAL_COMM_CFG_CH0_LO_ADDR 20'hf0118
`define SERIAL_COMM_CFG_CH0_HI_ADDR 20'hf0119
`define SERIAL_COMM_CFG_CH1_LO_ADDR 20'hf011a
`define SERIAL_COMM_CFG_CH1_HI_ADDR 20'hf011b
`define SERIAL_CHAN_ENABLED_ADDR 20'hf0120
`define SERIAL_CHAN_START_ADDR 20'hf0122
`define SERIAL_CHAN_STOP_ADDR 20'hf0124
`define SERIAL_CLOCK_SEL_ADDR 20'hf0126
`define SERIAL_OUTPUT_VALUE_ADDR 20'hf0128
`define SERIAL_CLOCK_OUTPUT_ADDR 20'hf0129
`define SERIAL_OUTPUT_ENABLE_ADDR 20'hf012a
`define SERIAL_OUTPUT_LEVEL_ADDR 20'hf0134
`define TIMER_COUNT_CH0_LO_ADDR 20'hf0180
`define TIMER_COUNT_CH0_HI_ADDR 20'hf0181
`define TIMER_COUNT_CH1_LO_ADDR 20'hf0182
`define TIMER_COUNT_CH1_HI_ADDR 20'hf0183
`define CLOCK_OUT_SELECT_ADDR 20'hfffa5
`define RESET_CAUSE_FLAGS_ADDR 20'hfffa8
`define WATCHDOG_ENABLE_KEY_ADDR 20'hfffab
`define IRQ_REQUEST_FLAGS_0_LO_ADDR 20'hfffe0

`define RST_ZERO 8'h00
`define RST_ONES 8'hff
`define PULLUP_OPT_PORT4_RST 8'h01
`define SERIAL_MODE_LO_RST 8'h20
`define SERIAL_COMM_CFG_LO_RST 8'h87
`define SERIAL_OUT_RST 8'h03
`define HS_OSC_DIVIDER_RST 8'h00
`define WATCHDOG_KEY_RST_A 8'h1a
`define WATCHDOG_KEY_RST_B 8'h9a

`define ILLEGAL_INSN_FLAG_BIT 7
`define WATCHDOG_RESET_FLAG_BIT 4
`define SUPPLY_MONITOR_RESET_FLAG_BIT 0

`define CAUSE_PIN_BIT 0
`define CAUSE_ILLEGAL_BIT 1
`define CAUSE_WATCHDOG_BIT 2
`define CAUSE_SUPPLY_BIT 3
`define CAUSE_RETENTION_BIT 4

`define OP_BYTE 2'h0
`define OP_BIT_SET 2'h1
`define OP_BIT_CLEAR 2'h2
`define OP_BIT_TEST 2'h3

`define NUM_RW_REGS 39
`define NUM_RO_INPUTS 8
`define IDX_RESET_CAUSE 6'd47
`define IDX_NONE 6'h3f

`endif

// ### test/sfr_map_decoder_props.sv
// Concurrent checks on the register bank ports
`timescale 1ns/10ps
`default_nettype none
`include "sfr_map_defs.vh"
module sfr_map_decoder_props #(
    parameter NRW = 39,
    parameter NRO = 8
) (
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic [4:0] RST_CAUSE,
    input wire logic OPT_WDT_KEY_SEL,
    input wire logic ACC_VALID,
    input wire logic ACC_WRITE,
    input wire logic [19:0] ACC_ADDR,
    input wire logic [1:0] ACC_OP,
    input wire logic [7:0] ACC_WDATA,
    input wire logic [7:0] RDATA,
    input wire logic DONE,
    input wire logic REFUSED,
    input wire logic LONG_FORM,
    input wire logic [1:0] EXTRA_BYTES,
    input wire logic [7:0] RESET_CAUSE,
    input wire logic [8*NRW-1:0] CFG_OUT
);
    logic armed_r;
    logic take;
    logic in_ext;
    logic in_short;
    // Low during reset and in the capture cycle after reset release
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            armed_r <= 1'b0;
        end else begin
            armed_r <= 1'b1;
        end
    end
    assign take = ACC_VALID && armed_r;
    assign in_ext = (ACC_ADDR >= `EXT_AREA_FIRST) && (ACC_ADDR <= `EXT_AREA_LAST);
    assign in_short = ACC_ADDR >= `SHORT_AREA_FIRST;
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_B);
    a_done_on_take: assert property (take |=> DONE) else $error("no done after access");
    a_done_idle: assert property (!ACC_VALID |=> !DONE) else $error("done without access");
    a_ext_long_form: assert property (take && in_ext |=> LONG_FORM && EXTRA_BYTES == `EXT_EXTRA_BYTES)
        else $error("extended access not long form");
    a_short_form: assert property (take && in_short |=> !LONG_FORM && EXTRA_BYTES == 2'h0)
        else $error("short access flagged long");
    a_stray_refused: assert property (take && !in_ext && !in_short
        |=> REFUSED && RDATA == 8'h00 && $stable(CFG_OUT))
        else $error("stray access not refused");
    a_ro_store_refused: assert property (take && ACC_OP == `OP_BYTE && ACC_WRITE
        && ACC_ADDR inside {`SERIAL_STATUS_CH0_ADDR, `TIMER_COUNT_CH0_LO_ADDR} |=> REFUSED && $stable(CFG_OUT))
        else $error("store to read-only taken");
    a_bit_op_guard: assert property (take && ACC_OP != `OP_BYTE
        && ACC_ADDR inside {`SERIAL_MODE_CH0_LO_ADDR, `WATCHDOG_ENABLE_KEY_ADDR} |=> REFUSED)
        else $error("bit op on byte-only register");
    a_store_lands: assert property (take && ACC_OP == `OP_BYTE && ACC_WRITE
        && ACC_ADDR == `PULLUP_OPT_PORT0_ADDR
        |=> CFG_OUT[15:8] == $past(ACC_WDATA) && RDATA == $past(ACC_WDATA)) else $error("store lost");
    a_key_strap: assert property (!armed_r |=> CFG_OUT[8*37 +: 8] ==
        ($past(OPT_WDT_KEY_SEL) ? `WATCHDOG_KEY_RST_B : `WATCHDOG_KEY_RST_A)) else $error("watchdog key reset wrong");
    a_illegal_flag: assert property (!armed_r && RST_CAUSE[1] |=> RESET_CAUSE[7]) else $error("illegal flag not set");
    a_pin_clears: assert property (!armed_r && RST_CAUSE inside {5'h01, 5'h10} |=> RESET_CAUSE == 8'h00)
        else $error("flags not cleared");
    a_wdt_flag: assert property (!armed_r && RST_CAUSE == 5'h04 |=> RESET_CAUSE[4]
        && RESET_CAUSE[7] == $past(RESET_CAUSE[7])) else $error("watchdog flag wrong");
    c_bit_test: cover property (take && ACC_OP == `OP_BIT_TEST);
    c_ext_store: cover property (take && in_ext && ACC_WRITE);
    c_wdt_reset: cover property (!armed_r && RST_CAUSE == 5'h04);
endmodule
bind sfr_map_decoder sfr_map_decoder_props #(.NRW(NRW), .NRO(NRO)) sfr_map_decoder_props_inst (
    .CLOCK(CLOCK), .RST_B(RST_B), .RST_CAUSE(RST_CAUSE), .OPT_WDT_KEY_SEL(OPT_WDT_KEY_SEL),
    .ACC_VALID(ACC_VALID), .ACC_WRITE(ACC_WRITE), .ACC_ADDR(ACC_ADDR), .ACC_OP(ACC_OP),
    .ACC_WDATA(ACC_WDATA), .RDATA(RDATA), .DONE(DONE), .REFUSED(REFUSED), .LONG_FORM(LONG_FORM),
    .EXTRA_BYTES(EXTRA_BYTES), .RESET_CAUSE(RESET_CAUSE), .CFG_OUT(CFG_OUT)
);
`default_nettype wire

// ### test/cpu_access_model.sv
// CPU-side model issuing byte and bit accesses
`timescale 1ns/10ps
`default_nettype none
module cpu_access_model (
    input wire logic CLOCK,
    input wire logic DONE,
    input wire logic REFUSED,
    input wire logic BIT_RESULT,
    input wire logic [7:0] RDATA,
    output logic ACC_VALID,
    output logic ACC_WRITE,
    output logic [19:0] ACC_ADDR,
    output logic [1:0] ACC_OP,
    output logic [2:0] ACC_BITPOS,
    output logic [7:0] ACC_WDATA
);
    initial begin
        ACC_VALID = 1'b0;
        ACC_WRITE = 1'b0;
        ACC_ADDR = 20'h00000;
        ACC_OP = 2'h0;
        ACC_BITPOS = 3'h0;
        ACC_WDATA = 8'h00;
    end
    // One access, answer sampled one cycle after the taking edge
    task automatic access(input logic wr, input logic [19:0] a, input logic [1:0] o, input logic [2:0] bp,
        input logic [7:0] wd, output logic [7:0] rd, output logic bt, output logic rf, output logic dn);
        @(posedge CLOCK);
        ACC_VALID <= 1'b1;
        ACC_WRITE <= wr;
        ACC_ADDR <= a; // Caller keeps to assigned places outside refusal
        ACC_OP <= o;
        ACC_BITPOS <= bp;
        ACC_WDATA <= wd;
        @(posedge CLOCK);
        ACC_VALID <= 1'b0;
        ACC_ADDR <= ~a;
        ACC_WDATA <= ~wd;
        @(posedge CLOCK);
        rd = RDATA;
        bt = BIT_RESULT;
        rf = REFUSED;
        dn = DONE;
    endtask
endmodule
`default_nettype wire

// ### test/sfr_map_decoder_tb_top.sv
// Testbench for the register bank
`timescale 1ns/10ps
`default_nettype none
`include "sfr_map_defs.vh"
module sfr_map_decoder_tb_top;
    logic CLOCK, RST_B, PWR_ON_RST_B, OPT_WDT_KEY_SEL, ACC_VALID, ACC_WRITE, BIT_RESULT, DONE, REFUSED, LONG_FORM;
    logic [4:0] RST_CAUSE;
    logic [19:0] ACC_ADDR;
    logic [1:0] ACC_OP, EXTRA_BYTES;
    logic [2:0] ACC_BITPOS;
    logic [7:0] ACC_WDATA, RDATA, RESET_CAUSE, rd;
    logic [63:0] STATUS_IN;
    logic [8*`NUM_RW_REGS-1:0] CFG_OUT;
    logic bt, rf, dn;
    int miscompares = 0;
    int cmp_count = 0;
    logic [19:0] ra [12] = '{`PULLUP_OPT_PORT4_ADDR, `ANALOG_DIGITAL_SEL_PORT1_ADDR, `SERIAL_MODE_CH1_LO_ADDR,
        `SERIAL_COMM_CFG_CH0_LO_ADDR, `SERIAL_CLOCK_OUTPUT_ADDR, `TIMER_COUNT_CH1_HI_ADDR, `SERIAL_STATUS_CH0_ADDR,
        `CLOCK_OUT_SELECT_ADDR, `WATCHDOG_ENABLE_KEY_ADDR, `RESET_CAUSE_FLAGS_ADDR, `HS_OSC_DIVIDER_ADDR,
        `ADC_MODE_2_ADDR};
    logic [7:0] rv [12] = '{8'h01, 8'hff, 8'h20, 8'h87, 8'h03, 8'hff, 8'h00, 8'h00, 8'h9a, 8'h00, 8'h00, 8'h00};
    logic [19:0] ua [3] = '{20'hf0001, 20'hf07ff, 20'h00100};
    logic [4:0] cz [4] = '{5'h02, 5'h04, 5'h08, 5'h10};
    logic [7:0] ce [4] = '{8'h80, 8'h90, 8'h91, 8'h00};
    sfr_map_decoder sfr_map_decoder_inst (.CLOCK(CLOCK), .RST_B(RST_B), .PWR_ON_RST_B(PWR_ON_RST_B),
        .RST_CAUSE(RST_CAUSE), .OPT_WDT_KEY_SEL(OPT_WDT_KEY_SEL), .ACC_VALID(ACC_VALID), .ACC_WRITE(ACC_WRITE),
        .ACC_ADDR(ACC_ADDR), .ACC_OP(ACC_OP), .ACC_BITPOS(ACC_BITPOS), .ACC_WDATA(ACC_WDATA), .STATUS_IN(STATUS_IN),
        .RDATA(RDATA), .BIT_RESULT(BIT_RESULT), .DONE(DONE), .REFUSED(REFUSED), .LONG_FORM(LONG_FORM),
        .EXTRA_BYTES(EXTRA_BYTES), .RESET_CAUSE(RESET_CAUSE), .CFG_OUT(CFG_OUT));
    cpu_access_model cpu_access_model_inst (.CLOCK(CLOCK), .DONE(DONE), .REFUSED(REFUSED), .BIT_RESULT(BIT_RESULT),
        .RDATA(RDATA), .ACC_VALID(ACC_VALID), .ACC_WRITE(ACC_WRITE), .ACC_ADDR(ACC_ADDR), .ACC_OP(ACC_OP),
        .ACC_BITPOS(ACC_BITPOS), .ACC_WDATA(ACC_WDATA));
    initial begin
        CLOCK = 1'b0;
        forever #12.5 CLOCK = ~CLOCK;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic op(input logic wr, input logic [19:0] a, input logic [1:0] o, input logic [2:0] bp,
        input logic [7:0] wd);
        cpu_access_model_inst.access(wr, a, o, bp, wd, rd, bt, rf, dn);
        chk({7'h00, dn}, 8'h01);
    endtask
    task automatic rst(input logic [4:0] cause, input logic strap);
        @(posedge CLOCK);
        RST_B <= 1'b0;
        RST_CAUSE <= cause;
        OPT_WDT_KEY_SEL <= strap;
        repeat (20) @(posedge CLOCK);
        RST_B <= 1'b1;
        PWR_ON_RST_B <= 1'b1;
        repeat (2) @(posedge CLOCK);
    endtask
    task automatic end_of_test;
        $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        RST_B = 1'b0;
        PWR_ON_RST_B = 1'b0;
        RST_CAUSE = 5'h01;
        OPT_WDT_KEY_SEL = 1'b1;
        STATUS_IN = 64'hffffffff00000000;
        rst(5'h01, 1'b1);
        foreach (ra[i]) begin
            op(1'b0, ra[i], `OP_BYTE, 3'h0, 8'h00);
            chk(rd, rv[i]);
        end
        op(1'b1, `PULLUP_OPT_PORT0_ADDR, `OP_BYTE, 3'h0, 8'h5a);
        chk(CFG_OUT[15:8], 8'h5a);
        chk({7'h00, LONG_FORM}, 8'h01);
        chk({6'h00, EXTRA_BYTES}, 8'h01);
        op(1'b1, `SERIAL_STATUS_CH0_ADDR, `OP_BYTE, 3'h0, 8'h33);
        chk({7'h00, rf}, 8'h01);
        STATUS_IN <= 64'hffffffff00005c00;
        op(1'b0, `SERIAL_STATUS_CH0_ADDR, `OP_BYTE, 3'h0, 8'h00);
        chk(rd, 8'h5c);
        op(1'b1, `CLOCK_OUT_SELECT_ADDR, `OP_BIT_SET, 3'h3, 8'h00);
        op(1'b0, `CLOCK_OUT_SELECT_ADDR, `OP_BIT_TEST, 3'h3, 8'h00);
        chk({7'h00, bt}, 8'h01);
        chk({7'h00, LONG_FORM}, 8'h00);
        op(1'b1, `CLOCK_OUT_SELECT_ADDR, `OP_BIT_CLEAR, 3'h3, 8'h00);
        op(1'b0, `CLOCK_OUT_SELECT_ADDR, `OP_BYTE, 3'h0, 8'h00);
        chk(rd, 8'h00);
        op(1'b1, `SERIAL_MODE_CH0_LO_ADDR, `OP_BIT_SET, 3'h0, 8'h00);
        chk({7'h00, rf}, 8'h01);
        op(1'b0, `SERIAL_MODE_CH0_LO_ADDR, `OP_BYTE, 3'h0, 8'h00);
        chk(rd, 8'h20);
        foreach (ua[i]) begin
            op(1'b1, ua[i], `OP_BYTE, 3'h0, 8'hff);
            chk({7'h00, rf}, 8'h01);
            op(1'b0, ua[i], `OP_BYTE, 3'h0, 8'h00);
            chk(rd, 8'h00);
        end
        op(1'b0, `PULLUP_OPT_PORT0_ADDR, `OP_BYTE, 3'h0, 8'h00);
        chk(rd, 8'h5a);
        for (int i = 0; i < 4; i++) begin
            rst(cz[i], i[0]);
            chk(RESET_CAUSE, ce[i]);
            op(1'b0, `WATCHDOG_ENABLE_KEY_ADDR, `OP_BYTE, 3'h0, 8'h00);
            chk(rd, i[0] ? 8'h9a : 8'h1a);
            op(1'b0, `PULLUP_OPT_PORT0_ADDR, `OP_BYTE, 3'h0, 8'h00);
            chk(rd, 8'h00);
        end
        end_of_test();
    end
    initial begin
        repeat (20000) @(posedge CLOCK);
        miscompares++;
        $display("[FAIL] %0t run did not finish", $time);
        end_of_test();
    end
endmodule
`default_nettype wire
